// File: src/ssb_map.vh
// Constants for the sleep sync status bank: register indices, flag bits, timing.
// Assumes a host command port that selects registers by index.
// Notes on behaviour
// - Missed sync tally saturates at FFFF
// - Host writes zero to clear the tally
// - Flag bit 0 set while network awake
// - Flag bit 1 set while acting coordinator
// - Flag bit 2 sticky on any valid sync
// - Flag bit 3 set on sync this wake
// - Flag bit 4 set when sleep settings change
// - Flag bit 5 set on self nomination request
// - Flag bit 6 set in deployment mode
// - Report active sleep interval, 10 ms units
// - Report active wake interval, 1 ms units
// - Nonzero wake delay holds off serial output
// - Received serial character stops wake delay timer
// - Configured sleep interval held in 10 ms units
`ifndef SSB_MAP_VH
`define SSB_MAP_VH

// ----------------------------------------
// Register indices on the command port
// ----------------------------------------
`define SSB_REG_TALLY 3'h0
`define SSB_REG_FLAGS 3'h1
`define SSB_REG_ASLEEP 3'h2
`define SSB_REG_AWAKE 3'h3
`define SSB_REG_WDELAY 3'h4
`define SSB_REG_CSLEEP 3'h5
`define SSB_REG_CWAKE 3'h6

// ----------------------------------------
// Flag bit positions and reset values
// ----------------------------------------
`define SSB_F_AWAKE 0
`define SSB_F_COORD 1
`define SSB_F_EVER 2
`define SSB_F_THIS 3
`define SSB_F_CHANGED 4
`define SSB_F_NOMINATE 5
`define SSB_F_DEPLOY 6
`define SSB_TALLY_MAX 16'hFFFF
`define SSB_WDELAY_RST 16'h0000
`define SSB_CSLEEP_RST 32'h000000C8
`define SSB_CWAKE_RST 32'h000007D0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSB_CLK_HZ 100000000
`define SSB_TICK_MS 1
`define SSB_TICK_CYC (`SSB_CLK_HZ / 1000 * `SSB_TICK_MS)
`define SSB_SLEEP_UNIT_MS 32'h0000000A
`define SSB_SLEEP_UNIT_RND 32'h00000009
`define SSB_SLEEP_MIN 32'h00000001

`endif

// File: src/ssb_ms_tick.v
// Millisecond tick divider for the sleep sync status bank.
// Assumes one clock and a synchronous copy of reset from the top.
`timescale 1ns/1ps
module ssb_ms_tick #(
  parameter CYCLES = 100000
) (
  input wire clk_i, // System clock
  input wire rst_n_i, // Synchronised reset, active low
  output reg tick_o // One-cycle pulse each millisecond
);
  reg [31:0] count;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Free running so every timer shares one phase
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (count == CYCLES - 1) begin
      count <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick_o <= 1'b0;
    end
  end
endmodule

// File: src/ssb_bank.v
// Sleep sync status bank: missed sync tally, sleep flags, active intervals,
// and the host wake delay timer. Assumes the sleep engine drives the state
// inputs from the same clock; pins and the serial strobe are synchronised here.
`timescale 1ns/1ps
`include "ssb_map.vh"
module ssb_bank #(
  parameter TICK_CYC = `SSB_TICK_CYC
) (
  input wire clk_i, // 100 MHz clock
  input wire arst_n_i, // Async reset, active low
  input wire cmd_wr_i, // Host register write strobe
  input wire cmd_rd_i, // Host register read strobe
  input wire [2:0] cmd_idx_i, // Register index
  input wire [31:0] cmd_wdata_i, // Write data
  output reg [31:0] cmd_rdata_o, // Read data
  output reg cmd_ack_o, // Read or write done
  input wire net_awake_i, // Network wake state
  input wire coord_i, // Acting as sleep coordinator
  input wire deploy_i, // Deployment mode
  input wire sync_rx_i, // Valid sync message pulse
  input wire wake_start_i, // Wake cycle begins, pulse
  input wire wake_end_i, // Wake cycle ends, pulse
  input wire settings_sent_i, // Sync with new settings sent
  input wire nominate_cmd_i, // Nomination command pulse
  input wire nominate_done_i, // Nomination carried out
  input wire button_pin_i, // Commissioning button pin, high pressed
  input wire serial_rx_pin_i, // Serial character strobe from pin domain
  input wire [31:0] net_sleep_i, // Sleep interval from network, 10 ms
  input wire [31:0] net_wake_i, // Wake interval from network, 1 ms
  input wire net_synced_i, // Use network intervals
  output reg [31:0] active_sleep_interval_o, // Sleep period in use
  output reg [31:0] active_wake_interval_o, // Wake period in use
  output wire host_hold_o // Hold off serial output and samples
);
  reg [1:0] rst_sync;
  wire rst_n;
  reg [15:0] missed_sync_tally;
  reg [15:0] host_wake_delay;
  reg [31:0] configured_sleep_interval;
  reg [31:0] configured_wake_interval;
  reg ever_sync;
  reg this_sync;
  reg changed;
  reg nominate;
  reg [15:0] hold_count;
  reg [1:0] btn_sync;
  reg btn_prev;
  reg [1:0] rx_sync;
  reg rx_prev;
  wire tick;
  wire btn_rise;
  wire rx_char;
  wire [7:0] flags;
  reg [31:0] next_sleep;

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Second stage only feeds the edge detectors
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      btn_sync <= 2'h0;
      btn_prev <= 1'b0;
      rx_sync <= 2'h0;
      rx_prev <= 1'b0;
    end else begin
      btn_sync <= {btn_sync[0], button_pin_i};
      btn_prev <= btn_sync[1];
      rx_sync <= {rx_sync[0], serial_rx_pin_i};
      rx_prev <= rx_sync[1];
    end
  end
  assign btn_rise = btn_sync[1] & ~btn_prev;
  assign rx_char = rx_sync[1] & ~rx_prev;

  ssb_ms_tick #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_o(tick)
  );

  // ----------------------------------------
  // Missed sync tally
  // ----------------------------------------
  // Host write wins over a same-cycle miss so a clear is never undone
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      missed_sync_tally <= 16'h0000;
    end else if (cmd_wr_i && cmd_idx_i == `SSB_REG_TALLY) begin
      missed_sync_tally <= cmd_wdata_i[15:0];
    end else if (wake_end_i && !this_sync && !sync_rx_i) begin
      if (missed_sync_tally != `SSB_TALLY_MAX) begin
        missed_sync_tally <= missed_sync_tally + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Sticky flags; every set beats its clear
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ever_sync <= 1'b0;
      this_sync <= 1'b0;
      changed <= 1'b0;
      nominate <= 1'b0;
    end else begin
      if (sync_rx_i) begin
        ever_sync <= 1'b1;
      end
      if (sync_rx_i) begin
        this_sync <= 1'b1;
      end else if (wake_start_i) begin
        this_sync <= 1'b0;
      end
      if (cmd_wr_i && (cmd_idx_i == `SSB_REG_CSLEEP || cmd_idx_i == `SSB_REG_CWAKE)) begin
        changed <= 1'b1;
      end else if (settings_sent_i) begin
        changed <= 1'b0;
      end
      if (btn_rise || nominate_cmd_i) begin
        nominate <= 1'b1;
      end else if (nominate_done_i) begin
        nominate <= 1'b0;
      end
    end
  end

  // Undocumented bit 7 reads zero; host must not rely on it
  assign flags = {1'b0, deploy_i, nominate, changed, this_sync, ever_sync, coord_i,
                  net_awake_i};

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_wake_delay <= `SSB_WDELAY_RST;
      configured_sleep_interval <= `SSB_CSLEEP_RST;
      configured_wake_interval <= `SSB_CWAKE_RST;
    end else if (cmd_wr_i) begin
      if (cmd_idx_i == `SSB_REG_WDELAY) begin
        host_wake_delay <= cmd_wdata_i[15:0];
      end else if (cmd_idx_i == `SSB_REG_CSLEEP) begin
        configured_sleep_interval <= cmd_wdata_i;
      end else if (cmd_idx_i == `SSB_REG_CWAKE) begin
        configured_wake_interval <= cmd_wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Active intervals
  // ----------------------------------------
  // Delay is in ms, sleep in 10 ms; subtract ceil(delay/10), floored at one unit
  always @* begin
    next_sleep = net_synced_i ? net_sleep_i : configured_sleep_interval;
    if (next_sleep > {16'h0000, host_wake_delay} / `SSB_SLEEP_UNIT_MS + `SSB_SLEEP_MIN) begin
      next_sleep = next_sleep -
                   ({16'h0000, host_wake_delay} + `SSB_SLEEP_UNIT_RND) / `SSB_SLEEP_UNIT_MS;
    end else if (host_wake_delay != 16'h0000) begin
      next_sleep = `SSB_SLEEP_MIN;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      active_sleep_interval_o <= `SSB_CSLEEP_RST;
      active_wake_interval_o <= `SSB_CWAKE_RST;
    end else begin
      active_sleep_interval_o <= next_sleep;
      active_wake_interval_o <= net_synced_i ? net_wake_i : configured_wake_interval;
    end
  end

  // ----------------------------------------
  // Host wake delay timer
  // ----------------------------------------
  // Loaded on wake; counts whole ticks, so first ms may be up to 1 ms short
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_count <= 16'h0000;
    end else if (rx_char) begin
      hold_count <= 16'h0000;
    end else if (wake_start_i) begin
      hold_count <= host_wake_delay;
    end else if (tick && hold_count != 16'h0000) begin
      hold_count <= hold_count - 16'h0001;
    end
  end
  assign host_hold_o = (hold_count != 16'h0000);

  // ----------------------------------------
  // Command port read and acknowledge
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata_o <= 32'h00000000;
      cmd_ack_o <= 1'b0;
    end else begin
      cmd_ack_o <= cmd_wr_i | cmd_rd_i;
      if (cmd_rd_i) begin
        if (cmd_idx_i == `SSB_REG_TALLY) begin
          cmd_rdata_o <= {16'h0000, missed_sync_tally};
        end else if (cmd_idx_i == `SSB_REG_FLAGS) begin
          cmd_rdata_o <= {24'h000000, flags};
        end else if (cmd_idx_i == `SSB_REG_ASLEEP) begin
          cmd_rdata_o <= active_sleep_interval_o;
        end else if (cmd_idx_i == `SSB_REG_AWAKE) begin
          cmd_rdata_o <= active_wake_interval_o;
        end else if (cmd_idx_i == `SSB_REG_WDELAY) begin
          cmd_rdata_o <= {16'h0000, host_wake_delay};
        end else if (cmd_idx_i == `SSB_REG_CSLEEP) begin
          cmd_rdata_o <= configured_sleep_interval;
        end else if (cmd_idx_i == `SSB_REG_CWAKE) begin
          cmd_rdata_o <= configured_wake_interval;
        end else begin
          cmd_rdata_o <= 32'h00000000;
        end
      end
    end
  end
endmodule

// File: testbench/ssb_bank_properties.sv
// Port checker for the sleep sync status bank.
// Assumes one clock domain; bound to every ssb_bank instance.
`timescale 1ns/1ps
module ssb_bank_checker (
  input wire clk_i, // Clock
  input wire arst_n_i, // Reset, active low
  input wire cmd_wr_i, // Write strobe
  input wire cmd_rd_i, // Read strobe
  input wire [2:0] cmd_idx_i, // Register index
  input wire [31:0] cmd_rdata_o, // Read data
  input wire cmd_ack_o, // Access done
  input wire net_awake_i, // Wake state
  input wire coord_i, // Coordinator
  input wire deploy_i, // Deployment
  input wire wake_start_i, // Wake begins
  input wire serial_rx_pin_i, // Serial character
  input wire [31:0] net_wake_i, // Network wake
  input wire net_synced_i, // Use network
  input wire [31:0] active_wake_interval_o, // Wake in use
  input wire host_hold_o // Hold off output
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Level flags must track a steady input at read time
  property p_awake; cmd_rd_i && cmd_idx_i == 3'h1 && $stable(net_awake_i)
    |=> cmd_rdata_o[0] == $past(net_awake_i); endproperty
  a_awake: assert property (p_awake) else $error("awake flag wrong");
  property p_coord; cmd_rd_i && cmd_idx_i == 3'h1 && $stable(coord_i)
    |=> cmd_rdata_o[1] == $past(coord_i); endproperty
  a_coord: assert property (p_coord) else $error("coordinator flag wrong");
  property p_deploy; cmd_rd_i && cmd_idx_i == 3'h1 && $stable(deploy_i)
    |=> cmd_rdata_o[6] == $past(deploy_i); endproperty
  a_deploy: assert property (p_deploy) else $error("deploy flag wrong");
  // Every access is answered exactly one cycle later
  property p_ack; cmd_rd_i || cmd_wr_i |=> cmd_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_noack; !cmd_rd_i && !cmd_wr_i |=> !cmd_ack_o; endproperty
  a_noack: assert property (p_noack) else $error("spurious ack");
  property p_rdhold; !cmd_rd_i |=> $stable(cmd_rdata_o); endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  // Hold only starts at a wake; a serial character ends it
  property p_hold_idle; !host_hold_o && !wake_start_i |=> !host_hold_o; endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("hold without wake");
  property p_ser; $rose(serial_rx_pin_i) |-> ##5 !host_hold_o; endproperty
  a_ser: assert property (p_ser) else $error("hold not stopped");
  property p_wake_iv; net_synced_i && $stable(net_synced_i) && $stable(net_wake_i)
    |=> active_wake_interval_o == $past(net_wake_i); endproperty
  a_wake_iv: assert property (p_wake_iv) else $error("wake interval wrong");
endmodule
bind ssb_bank ssb_bank_checker u_ssb_bank_checker (.*);

// File: testbench/ssb_host_model.sv
// Host model: drives the command port and the serial character strobe.
// Assumes strobes are one-cycle pulses answered by an ack one cycle later.
`timescale 1ns/1ps
module ssb_host_model (
  input wire clk_i, // Clock
  input wire cmd_ack_i, // Access done
  input wire [31:0] cmd_rdata_i, // Read data
  output reg cmd_wr_o, // Write strobe
  output reg cmd_rd_o, // Read strobe
  output reg [2:0] cmd_idx_o, // Register index
  output reg [31:0] cmd_wdata_o, // Write data
  output reg serial_o // Serial character strobe
);
  initial {cmd_wr_o, cmd_rd_o, cmd_idx_o, cmd_wdata_o, serial_o} = 38'h0;
  // One access; idle lines get inverted so stale values never pass
  task access(input w, input [2:0] i, input [31:0] d, output [31:0] q, output ok);
    integer n;
    begin
      @(posedge clk_i);
      #1;
      {cmd_wr_o, cmd_rd_o, cmd_idx_o, cmd_wdata_o} = {w, !w, i, d};
      @(posedge clk_i);
      #1;
      {cmd_wr_o, cmd_rd_o} = 2'b00;
      ok = 1'b0;
      q = 32'h0;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        @(posedge clk_i);
        if (cmd_ack_i === 1'b1) {ok, q} = {1'b1, cmd_rdata_i};
      end
      // Index and data stand until the ack edge has passed, then go stale
      #1;
      {cmd_idx_o, cmd_wdata_o} = {~i, ~d};
    end
  endtask
  // Serial character from the host
  task ser;
    begin
      @(posedge clk_i);
      #1 serial_o = 1'b1;
      repeat (5) @(posedge clk_i);
      #1 serial_o = 1'b0;
    end
  endtask
endmodule

// File: testbench/ssb_bank_tb.sv
// Testbench for the sleep sync status bank, driven through the host model.
// Assumes the design register map header is on the include path.
`timescale 1ns/1ps
`include "ssb_map.vh"
module ssb_bank_tb;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg [5:0] ev = 6'h00; // done, nominate, sent, wake end, wake start, sync
  reg awk = 1'b0, crd = 1'b0, dep = 1'b0, btn = 1'b0, syn = 1'b0, ok;
  reg [31:0] v;
  wire wr, rdq, ack, ser, hold;
  wire [2:0] idx;
  wire [31:0] wd, rd_d, asl, awa;
  integer num_errors = 0;
  integer n_compared = 0;
  integer k;
  always #5 clk_i = ~clk_i;
  ssb_host_model u_ssb_host_model (.clk_i(clk_i), .cmd_ack_i(ack), .cmd_rdata_i(rd_d),
    .cmd_wr_o(wr), .cmd_rd_o(rdq), .cmd_idx_o(idx), .cmd_wdata_o(wd), .serial_o(ser));
  ssb_bank #(.TICK_CYC(10)) u_ssb_bank (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_wr_i(wr),
    .cmd_rd_i(rdq), .cmd_idx_i(idx), .cmd_wdata_i(wd), .cmd_rdata_o(rd_d), .cmd_ack_o(ack),
    .net_awake_i(awk), .coord_i(crd), .deploy_i(dep), .sync_rx_i(ev[0]),
    .wake_start_i(ev[1]), .wake_end_i(ev[2]), .settings_sent_i(ev[3]),
    .nominate_cmd_i(ev[4]), .nominate_done_i(ev[5]), .button_pin_i(btn),
    .serial_rx_pin_i(ser), .net_sleep_i(32'h00000064), .net_wake_i(32'h00000050),
    .net_synced_i(syn), .active_sleep_interval_o(asl), .active_wake_interval_o(awa),
    .host_hold_o(hold));
  task tally_and_finish;
    begin
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [39:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("FAIL %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // A lost ack ends the run at once
  task bus(input w, input [2:0] i, input [31:0] d);
    begin
      u_ssb_host_model.access(w, i, d, v, ok);
      if (ok !== 1'b1) begin
        num_errors = num_errors + 1;
        tally_and_finish;
      end
    end
  endtask
  task rd(input [2:0] i, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, i, 32'h0);
      chk({"idx", 8'h30 + i, " "}, v & m, e);
    end
  endtask
  task pulse(input [5:0] m);
    begin
      @(posedge clk_i);
      #1 ev = m;
      @(posedge clk_i);
      #1 ev = 6'h00;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`SSB_REG_WDELAY, 32'hFFFFFFFF, `SSB_WDELAY_RST);
    rd(`SSB_REG_CSLEEP, 32'hFFFFFFFF, `SSB_CSLEEP_RST);
    rd(`SSB_REG_ASLEEP, 32'hFFFFFFFF, `SSB_CSLEEP_RST);
    rd(`SSB_REG_AWAKE, 32'hFFFFFFFF, `SSB_CWAKE_RST);
    rd(3'h7, 32'hFFFFFFFF, 32'h0);
    rd(`SSB_REG_FLAGS, 32'h7F, 32'h0);
    bus(1'b1, `SSB_REG_TALLY, 32'h0);
    pulse(6'h02);
    pulse(6'h04);
    rd(`SSB_REG_TALLY, 32'hFFFFFFFF, 32'h1);
    pulse(6'h02);
    pulse(6'h01);
    rd(`SSB_REG_FLAGS, 32'h0C, 32'h0C);
    pulse(6'h04);
    rd(`SSB_REG_TALLY, 32'hFFFFFFFF, 32'h1);
    pulse(6'h02);
    rd(`SSB_REG_FLAGS, 32'h0C, 32'h04);
    bus(1'b1, `SSB_REG_TALLY, 32'hFFFE);
    for (k = 0; k < 3; k = k + 1) begin
      pulse(6'h02);
      pulse(6'h04);
    end
    rd(`SSB_REG_TALLY, 32'hFFFFFFFF, `SSB_TALLY_MAX);
    bus(1'b1, `SSB_REG_TALLY, 32'h0);
    pulse(6'h04);
    rd(`SSB_REG_TALLY, 32'hFFFFFFFF, 32'h1);
    bus(1'b1, `SSB_REG_CSLEEP, 32'hC8);
    rd(`SSB_REG_FLAGS, 32'h10, 32'h10);
    pulse(6'h08);
    rd(`SSB_REG_FLAGS, 32'h10, 32'h0);
    bus(1'b1, `SSB_REG_CWAKE, 32'h3E8);
    rd(`SSB_REG_FLAGS, 32'h10, 32'h10);
    rd(`SSB_REG_AWAKE, 32'hFFFFFFFF, 32'h3E8);
    pulse(6'h10);
    rd(`SSB_REG_FLAGS, 32'h20, 32'h20);
    pulse(6'h20);
    rd(`SSB_REG_FLAGS, 32'h20, 32'h0);
    #1 btn = 1'b1;
    repeat (5) @(posedge clk_i);
    rd(`SSB_REG_FLAGS, 32'h20, 32'h20);
    {awk, crd, dep} = 3'b111;
    repeat (2) @(posedge clk_i);
    rd(`SSB_REG_FLAGS, 32'h43, 32'h43);
    bus(1'b1, `SSB_REG_WDELAY, 32'h3);
    rd(`SSB_REG_ASLEEP, 32'hFFFFFFFF, 32'hC7);
    pulse(6'h02);
    chk("hold ", hold, 1'b1);
    repeat (17) @(posedge clk_i);
    #1 chk("hold ", hold, 1'b1);
    repeat (14) @(posedge clk_i);
    #1 chk("hold ", hold, 1'b0);
    pulse(6'h02);
    u_ssb_host_model.ser;
    chk("hold ", hold, 1'b0);
    bus(1'b1, `SSB_REG_WDELAY, 32'h0);
    syn = 1'b1;
    repeat (2) @(posedge clk_i);
    rd(`SSB_REG_ASLEEP, 32'hFFFFFFFF, 32'h64);
    chk("awake", awa, 32'h50);
    tally_and_finish;
  end
endmodule
